// ===== hw/ewc_checker.sv
// encrypted write data packet checker with status reporting
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "ewc_defs.svh"
module ewc_checker (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic [7:0]       bus_addr,
   input  wire ewc_pkg::ewc_word_t bus_wdata,
   input  wire logic             bus_wr,
   input  wire logic             bus_rd,
   output ewc_pkg::ewc_word_t    bus_rdata,
   input  wire logic             rx_valid,
   input  wire ewc_pkg::ewc_byte_t rx_byte,
   input  wire logic             lifecycle_forbid,
   input  wire logic             no_reset_since,
   input  wire logic [1:0]       auth_level,
   input  wire logic             boot_flag,
   input  wire logic             dual_mode,
   input  wire logic [2:0]       bank_swap_field,
   input  wire logic [2:0]       secure_bank_swap_field,
   input  wire logic             permanent_block_protect,
   input  wire logic             flash_controller_err,
   input  wire ewc_pkg::ewc_word_t flash_status,
   input  wire logic             trusted_fail,
   input  wire logic             param_undefined,
   input  wire logic [1:0]       transition_pattern,
   input  wire logic             locked_boot_disabled,
   input  wire logic             hw_abnormal,
   input  wire ewc_pkg::ewc_word_t start_address,
   input  wire ewc_pkg::ewc_word_t write_size,
   input  wire ewc_pkg::ewc_word_t write_access_unit,
   input  wire logic             size_mismatch,
   input  wire logic             area_outside,
   input  wire logic             area_kind_mixed,
   input  wire logic             boundary_blocked,
   input  wire logic             lock_hit,
   input  wire logic             config_area,
   input  wire logic             readback_mismatch,
   input  wire logic             ext_driver_err,
   output logic                  report_valid,
   output ewc_pkg::ewc_byte_t    status_code,
   output ewc_pkg::ewc_word_t    status_details,
   output ewc_pkg::ewc_word_t    fail_address,
   output logic                  busy
);
   import ewc_pkg::*;

   ewc_state_e state_ff;
   ewc_state_e nxt_state;
   logic [15:0] len_ff;
   logic [15:0] left_ff;
   ewc_byte_t   sum_ff;
   ewc_byte_t   res_ff;
   logic        len_bad_ff;
   logic        etx_bad_ff;
   logic        sum_bad_ff;
   logic        enc_mode_ff;
   logic [7:0]  exp_rsp_ff;
   logic [15:0] exp_len_ff;
   ewc_word_t   load_limit_ff;
   ewc_word_t   load_total_ff;
   ewc_word_t   nxt_total;
   ewc_byte_t   status_ff;
   ewc_word_t   details_ff;
   ewc_word_t   fail_ff;
   logic        report_ff;
   ewc_word_t   rdata_ff;
   logic [15:0] rx_len;
   logic        arm_wr;
   ewc_byte_t   nxt_code;

   // misaligned against a power-of-two unit, or unit zero
   function automatic logic unit_misaligned(input ewc_word_t val, input ewc_word_t unit);
      unit_misaligned = (unit == 32'h0) || ((val & (unit - 32'h1)) != 32'h0);
   endfunction

   assign rx_len    = {len_ff[15:8], rx_byte};
   assign arm_wr    = bus_wr && (bus_addr == `EWC_ADR_CTRL) && bus_wdata[`EWC_CTRL_ARM];
   assign nxt_total = load_total_ff + {16'h0, len_ff} - 32'h1;

   // packet framing state machine
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         EWC_IDLE: begin
            if (arm_wr) begin
               nxt_state = EWC_SOD;
            end
         end
         EWC_SOD: begin
            if (rx_valid && rx_byte == `EWC_DATA_START) begin
               nxt_state = EWC_LNH;
            end
         end
         EWC_LNH: begin
            if (rx_valid) begin
               nxt_state = EWC_LNL;
            end
         end
         EWC_LNL: begin
            if (rx_valid) begin
               if (rx_len == 16'h0 || rx_len > `EWC_LEN_MAX) begin
                  nxt_state = EWC_CHECK;
               end else begin
                  nxt_state = EWC_RES;
               end
            end
         end
         EWC_RES: begin
            if (rx_valid) begin
               nxt_state = (len_ff == 16'h1) ? EWC_SUM : EWC_DATA;
            end
         end
         EWC_DATA: begin
            if (rx_valid && left_ff == 16'h1) begin
               nxt_state = EWC_SUM;
            end
         end
         EWC_SUM: begin
            if (rx_valid) begin
               nxt_state = EWC_ETX;
            end
         end
         EWC_ETX: begin
            if (rx_valid) begin
               nxt_state = EWC_CHECK;
            end
         end
         EWC_CHECK: begin
            nxt_state = EWC_IDLE;
         end
         default: begin
            nxt_state = EWC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= EWC_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // length, checksum and trailer capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         len_ff     <= 16'h0;
         left_ff    <= 16'h0;
         sum_ff     <= 8'h0;
         res_ff     <= 8'h0;
         len_bad_ff <= 1'b0;
         etx_bad_ff <= 1'b0;
         sum_bad_ff <= 1'b0;
      end else if (ce && rx_valid) begin
         case (state_ff)
            EWC_SOD: begin
               len_bad_ff <= 1'b0;
               etx_bad_ff <= 1'b0;
               sum_bad_ff <= 1'b0;
            end
            EWC_LNH: begin
               len_ff <= {rx_byte, 8'h0};
               sum_ff <= rx_byte;
            end
            EWC_LNL: begin
               len_ff     <= rx_len;
               left_ff    <= rx_len - 16'h1;
               sum_ff     <= sum_ff + rx_byte;
               len_bad_ff <= (rx_len == 16'h0) || (rx_len > `EWC_LEN_MAX);
            end
            EWC_RES: begin
               res_ff <= rx_byte;
               sum_ff <= sum_ff + rx_byte;
            end
            EWC_DATA: begin
               left_ff <= left_ff - 16'h1;
               sum_ff  <= sum_ff + rx_byte;
            end
            EWC_SUM: begin
               sum_bad_ff <= (ewc_byte_t'(sum_ff + rx_byte) != 8'h0);
            end
            EWC_ETX: begin
               etx_bad_ff <= (rx_byte != `EWC_TRAILER);
            end
            default: begin
               sum_ff <= sum_ff;
            end
         endcase
      end
   end

   // error priority, highest first
   always_comb begin
      nxt_code = `EWC_ST_OK;
      if (etx_bad_ff) begin
         nxt_code = `EWC_ST_PACKET;
      end else if (sum_bad_ff) begin
         nxt_code = `EWC_ST_CHECKSUM;
      end else if (len_bad_ff || len_ff != exp_len_ff) begin
         nxt_code = `EWC_ST_PACKET;
      end else if (res_ff == `EWC_RSP_ERR) begin
         nxt_code = `EWC_ST_CANCEL;
      end else if (lifecycle_forbid || no_reset_since) begin
         nxt_code = `EWC_ST_ACCEPT;
      end else if (auth_level <= `EWC_AUTH_ONE) begin
         nxt_code = `EWC_ST_SECURE;
      end else if (!boot_flag || permanent_block_protect || (dual_mode &&
                   (bank_swap_field != `EWC_SWAP_OK ||
                    secure_bank_swap_field != `EWC_SWAP_OK))) begin
         nxt_code = `EWC_ST_PROTECT;
      end else if (flash_controller_err) begin
         nxt_code = `EWC_ST_FLASH;
      end else if (res_ff != exp_rsp_ff) begin
         nxt_code = `EWC_ST_PACKET;
      end else if (trusted_fail) begin
         nxt_code = `EWC_ST_TRUSTED;
      end else if (param_undefined) begin
         nxt_code = `EWC_ST_PARAM;
      end else if (transition_pattern == `EWC_TRN_LOCKED && locked_boot_disabled) begin
         nxt_code = `EWC_ST_PROTECT;
      end else if (hw_abnormal) begin
         nxt_code = `EWC_ST_HARDWARE;
      end else if ((enc_mode_ff && nxt_total > load_limit_ff) || size_mismatch ||
                   area_outside || area_kind_mixed ||
                   unit_misaligned(start_address, write_access_unit) ||
                   unit_misaligned(write_size, write_access_unit) ||
                   ((start_address & `EWC_CIPHER_MASK) != 32'h0)) begin
         nxt_code = `EWC_ST_PARAM;
      end else if (boundary_blocked) begin
         nxt_code = `EWC_ST_ADDRESS;
      end else if (lock_hit) begin
         nxt_code = `EWC_ST_PROTECT;
      end else if (config_area && readback_mismatch) begin
         nxt_code = `EWC_ST_VERIFY;
      end else if (ext_driver_err) begin
         nxt_code = `EWC_ST_FLASH;
      end
   end

   // status report
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_ff  <= `EWC_ST_OK;
         details_ff <= `EWC_ALL_ONES;
         fail_ff    <= `EWC_ALL_ONES;
         report_ff  <= 1'b0;
      end else if (ce) begin
         report_ff <= (state_ff == EWC_CHECK);
         if (state_ff == EWC_CHECK) begin
            status_ff <= nxt_code;
            fail_ff   <= `EWC_ALL_ONES;
            if (nxt_code == `EWC_ST_FLASH && flash_controller_err) begin
               details_ff <= flash_status;
            end else begin
               details_ff <= `EWC_ALL_ONES;
            end
         end
      end
   end

   // encrypted data load accumulation
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         load_total_ff <= 32'h0;
      end else if (ce) begin
         if (bus_wr && bus_addr == `EWC_ADR_CTRL && bus_wdata[`EWC_CTRL_CLR]) begin
            load_total_ff <= 32'h0;
         end else if (state_ff == EWC_CHECK && enc_mode_ff && nxt_code == `EWC_ST_OK) begin
            load_total_ff <= nxt_total;
         end
      end
   end

   // software registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         enc_mode_ff   <= 1'b0;
         exp_rsp_ff    <= 8'h0;
         exp_len_ff    <= 16'h0;
         load_limit_ff <= `EWC_LIMIT_RST;
      end else if (ce && bus_wr) begin
         case (bus_addr)
            `EWC_ADR_CTRL: begin
               enc_mode_ff <= bus_wdata[`EWC_CTRL_ENC];
            end
            `EWC_ADR_EXPECT: begin
               exp_rsp_ff <= bus_wdata[7:0];
               exp_len_ff <= bus_wdata[23:8];
            end
            `EWC_ADR_LIMIT: begin
               load_limit_ff <= bus_wdata;
            end
            default: begin
               exp_rsp_ff <= exp_rsp_ff;
            end
         endcase
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h0;
      end else if (ce) begin
         rdata_ff <= 32'h0;
         if (bus_rd) begin
            case (bus_addr)
               `EWC_ADR_CTRL:    rdata_ff <= {30'h0, enc_mode_ff, 1'b0};
               `EWC_ADR_EXPECT:  rdata_ff <= {8'h0, exp_len_ff, exp_rsp_ff};
               `EWC_ADR_LIMIT:   rdata_ff <= load_limit_ff;
               `EWC_ADR_STATUS:  rdata_ff <= {19'h0, state_ff, status_ff, busy_w()};
               `EWC_ADR_DETAILS: rdata_ff <= details_ff;
               `EWC_ADR_FAILADR: rdata_ff <= fail_ff;
               `EWC_ADR_TOTAL:   rdata_ff <= load_total_ff;
               default:          rdata_ff <= 32'h0;
            endcase
         end
      end
   end

   function automatic logic [0:0] busy_w();
      busy_w = (state_ff != EWC_IDLE);
   endfunction

   logic busy_ff;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_ff <= 1'b0;
      end else if (ce) begin
         busy_ff <= (nxt_state != EWC_IDLE);
      end
   end

   assign bus_rdata      = rdata_ff;
   assign report_valid   = report_ff;
   assign status_code    = status_ff;
   assign status_details = details_ff;
   assign fail_address   = fail_ff;
   assign busy           = busy_ff;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst || !ce);

   sequence s_bad_trailer;
      state_ff == EWC_ETX && rx_valid && rx_byte != `EWC_TRAILER;
   endsequence

   sequence s_bad_sum;
      state_ff == EWC_ETX && rx_valid && rx_byte == `EWC_TRAILER && !etx_bad_ff && sum_bad_ff;
   endsequence

   a_sod_wait: assert property (
      state_ff == EWC_SOD && rx_valid && rx_byte != `EWC_DATA_START |=> state_ff == EWC_SOD)
      else $error("non start byte left the wait");
   a_trailer_err: assert property (
      s_bad_trailer ##1 ce |=> status_ff == `EWC_ST_PACKET && report_ff)
      else $error("missing trailer not reported");
   a_sum_err: assert property (
      s_bad_sum ##1 ce |=> status_ff == `EWC_ST_CHECKSUM)
      else $error("checksum error not reported");
   a_pkt_fields: assert property (
      report_ff && status_ff inside {`EWC_ST_PACKET, `EWC_ST_CHECKSUM}
      |-> details_ff == `EWC_ALL_ONES && fail_ff == `EWC_ALL_ONES)
      else $error("packet error fields not all ones");
   a_back_idle: assert property (
      report_ff |-> state_ff == EWC_IDLE)
      else $error("not idle after report");
   a_ok_fields: assert property (
      report_ff && status_ff == `EWC_ST_OK |-> details_ff == `EWC_ALL_ONES)
      else $error("ok details not all ones");
   a_accept_err: assert property (
      state_ff == EWC_CHECK && !etx_bad_ff && !sum_bad_ff && !len_bad_ff &&
      len_ff == exp_len_ff && res_ff != `EWC_RSP_ERR && lifecycle_forbid
      |=> status_ff == `EWC_ST_ACCEPT)
      else $error("acceptance error not reported");
   a_load_limit: assert property (
      report_ff && status_ff == `EWC_ST_OK && enc_mode_ff |-> load_total_ff <= load_limit_ff)
      else $error("load total passed the limit");
endmodule

// ===== hw/ewc_defs.svh
// constants for the encrypted write packet checker
`ifndef EWC_DEFS_SVH
`define EWC_DEFS_SVH
`define EWC_DATA_START    8'h81
`define EWC_TRAILER       8'h03
`define EWC_RSP_ERR       8'hff
`define EWC_LEN_MAX       16'h0401
`define EWC_ALL_ONES      32'hffffffff
`define EWC_CIPHER_MASK   32'h0000000f
`define EWC_SWAP_OK       3'h7
`define EWC_AUTH_ONE      2'h1
`define EWC_TRN_LOCKED    2'h2
`define EWC_ADR_CTRL      8'h00
`define EWC_ADR_EXPECT    8'h04
`define EWC_ADR_LIMIT     8'h08
`define EWC_ADR_STATUS    8'h0c
`define EWC_ADR_DETAILS   8'h10
`define EWC_ADR_FAILADR   8'h14
`define EWC_ADR_TOTAL     8'h18
`define EWC_CTRL_ARM      0
`define EWC_CTRL_ENC      1
`define EWC_CTRL_CLR      2
`define EWC_LIMIT_RST     32'h00010000
`define EWC_ST_OK         8'h00
`define EWC_ST_PACKET     8'hc1
`define EWC_ST_CHECKSUM   8'hc2
`define EWC_ST_ACCEPT     8'hc3
`define EWC_ST_SECURE     8'hc4
`define EWC_ST_PROTECT    8'hc5
`define EWC_ST_FLASH      8'hc6
`define EWC_ST_TRUSTED    8'hc7
`define EWC_ST_PARAM      8'hc8
`define EWC_ST_HARDWARE   8'hc9
`define EWC_ST_ADDRESS    8'hca
`define EWC_ST_VERIFY     8'hcb
`define EWC_ST_CANCEL     8'hcc
`endif

// ===== hw/ewc_pkg.sv
// types for the encrypted write packet checker
package ewc_pkg;
   typedef enum logic [3:0] {
      EWC_IDLE  = 4'h0,
      EWC_SOD   = 4'h1,
      EWC_LNH   = 4'h2,
      EWC_LNL   = 4'h3,
      EWC_RES   = 4'h4,
      EWC_DATA  = 4'h5,
      EWC_SUM   = 4'h6,
      EWC_ETX   = 4'h7,
      EWC_CHECK = 4'h8
   } ewc_state_e;
   typedef logic [7:0] ewc_byte_t;
   typedef logic [31:0] ewc_word_t;
endpackage

// ===== testbench/ewc_host.sv
// host side model that frames and sends data packets
`timescale 1ns/10ps
`include "ewc_defs.svh"
module ewc_host (
   input  wire logic          ref_clk,
   output logic               rx_valid,
   output ewc_pkg::ewc_byte_t rx_byte
);
   import ewc_pkg::*;
   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
   end
   task automatic put(input ewc_byte_t b);
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_byte  <= b;
   endtask
   // released link shows the inverse of the last byte
   task automatic stop();
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_byte  <= ~rx_byte;
   endtask
   task automatic send(input logic [15:0] len, input ewc_byte_t res, input ewc_byte_t serr,
                       input ewc_byte_t tail);
      ewc_byte_t sum;
      sum = len[15:8] + len[7:0] + res;
      put(`EWC_DATA_START);
      put(len[15:8]);
      put(len[7:0]);
      if (len != 16'h0000 && len <= `EWC_LEN_MAX) begin
         put(res);
         for (int i = 1; i < int'(len); i++) begin
            put(8'(i));
            sum = sum + 8'(i);
         end
         put(8'h00 - sum + serr);
         put(tail);
      end
      stop();
   endtask
endmodule

// ===== testbench/test_ewc_checker.sv
// self-checking testbench for the encrypted write packet checker
`timescale 1ns/10ps
`include "ewc_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module test_ewc_checker;
   import ewc_pkg::*;
   localparam logic [15:0] LEN      = 16'h0005;
   localparam ewc_byte_t   RES      = 8'h15;
   localparam ewc_word_t   FLASH_ST = 32'h0000a5c3;
   localparam ewc_word_t   ONES     = `EWC_ALL_ONES;
   logic        ref_clk;
   logic        rst;
   logic [7:0]  bus_addr;
   ewc_word_t   bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   ewc_word_t   bus_rdata;
   logic        rx_valid;
   ewc_byte_t   rx_byte;
   logic [23:0] fl;
   logic        enc;
   logic        report_valid;
   ewc_byte_t   status_code;
   ewc_word_t   status_details;
   ewc_word_t   fail_address;
   logic        busy;
   int          failures;
   int          cmp_count;
   int          cyc;
   int          rep_cnt;
   int          n0;
   logic [31:0] tab [30] = '{
      {`EWC_ST_ACCEPT, 24'h000001},
      {`EWC_ST_ACCEPT, 24'h000002},
      {`EWC_ST_SECURE, 24'h000004},
      {`EWC_ST_SECURE, 24'h000008},
      {`EWC_ST_PROTECT, 24'h000010},
      {`EWC_ST_PROTECT, 24'h000020},
      {`EWC_ST_PROTECT, 24'h000040},
      {`EWC_ST_PROTECT, 24'h000080},
      {`EWC_ST_OK, 24'h800020},
      {`EWC_ST_OK, 24'h800800},
      {`EWC_ST_OK, 24'h880000},
      {`EWC_ST_FLASH, 24'h000100},
      {`EWC_ST_TRUSTED, 24'h000200},
      {`EWC_ST_PARAM, 24'h000400},
      {`EWC_ST_PROTECT, 24'h000800},
      {`EWC_ST_HARDWARE, 24'h001000},
      {`EWC_ST_PARAM, 24'h002000},
      {`EWC_ST_PARAM, 24'h004000},
      {`EWC_ST_PARAM, 24'h008000},
      {`EWC_ST_PARAM, 24'h010000},
      {`EWC_ST_ADDRESS, 24'h020000},
      {`EWC_ST_PROTECT, 24'h040000},
      {`EWC_ST_VERIFY, 24'h080000},
      {`EWC_ST_FLASH, 24'h100000},
      {`EWC_ST_PARAM, 24'h200000},
      {`EWC_ST_PARAM, 24'h400000},
      {`EWC_ST_ACCEPT, 24'h000005},
      {`EWC_ST_SECURE, 24'h000014},
      {`EWC_ST_HARDWARE, 24'h041000},
      {`EWC_ST_ADDRESS, 24'h120000}
   };

   ewc_host u_ewc_host (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));

   ewc_checker u_ewc_checker (
      .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_valid(rx_valid),
      .rx_byte(rx_byte), .lifecycle_forbid(fl[0]), .no_reset_since(fl[1]),
      .auth_level(fl[3] ? 2'h0 : (fl[2] ? `EWC_AUTH_ONE : 2'h2)), .boot_flag(~fl[4]),
      .dual_mode(~fl[23]), .bank_swap_field(fl[5] ? 3'h3 : `EWC_SWAP_OK),
      .secure_bank_swap_field(fl[6] ? 3'h6 : `EWC_SWAP_OK), .permanent_block_protect(fl[7]),
      .flash_controller_err(fl[8]), .flash_status(FLASH_ST), .trusted_fail(fl[9]),
      .param_undefined(fl[10]),
      .transition_pattern((fl[11] && !fl[23]) ? `EWC_TRN_LOCKED : 2'h0),
      .locked_boot_disabled(fl[11]), .hw_abnormal(fl[12]),
      .start_address(fl[13] ? 32'h00000104 : 32'h00000100),
      .write_size(fl[21] ? 32'h00000012 : 32'h00000010),
      .write_access_unit(fl[22] ? 32'h00000000 : 32'h00000004), .size_mismatch(fl[14]),
      .area_outside(fl[15]), .area_kind_mixed(fl[16]), .boundary_blocked(fl[17]),
      .lock_hit(fl[18]), .config_area(fl[19] && !fl[23]), .readback_mismatch(fl[19]),
      .ext_driver_err(fl[20]), .report_valid(report_valid), .status_code(status_code),
      .status_details(status_details), .fail_address(fail_address), .busy(busy)
   );

   always #2 ref_clk = ~ref_clk;

   // report counter and hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (report_valid === 1'b1)
         rep_cnt++;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic wr(input logic [7:0] a, input ewc_word_t d);
      @(posedge ref_clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input ewc_word_t e);
      @(posedge ref_clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1;
      `CHK(bus_rdata, e)
   endtask

   // arm, send one packet, wait for the report and check it
   task automatic pkt(input logic [15:0] len, input ewc_byte_t res, input ewc_byte_t serr,
                      input ewc_byte_t tail, input logic [23:0] f, input ewc_byte_t code,
                      input logic pre);
      int n = 0;
      @(posedge ref_clk);
      fl <= f;
      wr(`EWC_ADR_CTRL, {30'h0, enc, 1'b1});
      if (pre) begin
         u_ewc_host.put(8'h55);
         u_ewc_host.put(`EWC_TRAILER);
      end
      u_ewc_host.send(len, res, serr, tail);
      #1;
      while (report_valid !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (len != 16'h0000 && len <= `EWC_LEN_MAX)
         `CHK(n, 1)
      `CHK(status_code, code)
      `CHK(status_details, (f[8] && code == `EWC_ST_FLASH) ? FLASH_ST : ONES)
      `CHK(fail_address, ONES)
      `CHK(busy, 1'b0)
   endtask

   initial begin
      ref_clk   = 1'b0;
      rst       = 1'b1;
      bus_addr  = 8'h00;
      bus_wdata = 32'h00000000;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      fl        = 24'h000000;
      enc       = 1'b0;
      failures  = 0;
      cmp_count = 0;
      cyc       = 0;
      rep_cnt   = 0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      `CHK(status_code, `EWC_ST_OK)
      `CHK(status_details, ONES)
      `CHK(busy, 1'b0)
      rd(`EWC_ADR_LIMIT, `EWC_LIMIT_RST);
      rd(8'h40, 32'h00000000);
      done("reset");
      wr(`EWC_ADR_EXPECT, {8'h00, LEN, RES});
      pkt(LEN, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_OK, 1'b1);
      pkt(LEN, RES, 8'h00, 8'h04, 24'h0, `EWC_ST_PACKET, 1'b0);
      rd(`EWC_ADR_STATUS, {23'h0, `EWC_ST_PACKET, 1'b0});
      rd(`EWC_ADR_DETAILS, ONES);
      rd(`EWC_ADR_FAILADR, ONES);
      pkt(LEN, RES, 8'h01, `EWC_TRAILER, 24'h0, `EWC_ST_CHECKSUM, 1'b0);
      pkt(16'h0006, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_PACKET, 1'b0);
      pkt(16'h0000, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_PACKET, 1'b0);
      pkt(16'h0402, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_PACKET, 1'b0);
      pkt(LEN, 8'h16, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_PACKET, 1'b0);
      pkt(LEN, `EWC_RSP_ERR, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_CANCEL, 1'b0);
      pkt(LEN, RES, 8'h01, `EWC_TRAILER, 24'h000001, `EWC_ST_CHECKSUM, 1'b0);
      pkt(LEN, 8'h16, 8'h00, `EWC_TRAILER, 24'h000100, `EWC_ST_FLASH, 1'b0);
      done("framing");
      @(posedge ref_clk);
      #1;
      n0 = rep_cnt;
      u_ewc_host.send(LEN, RES, 8'h00, `EWC_TRAILER);
      repeat (12) @(posedge ref_clk);
      #1;
      `CHK(rep_cnt, n0)
      `CHK(busy, 1'b0)
      done("idle");
      for (int i = 0; i < 30; i++)
         pkt(LEN, RES, 8'h00, `EWC_TRAILER, tab[i][23:0], tab[i][31:24], 1'b0);
      done("checks");
      wr(`EWC_ADR_CTRL, 32'h00000004);
      pkt(LEN, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_OK, 1'b0);
      rd(`EWC_ADR_TOTAL, 32'h00000000);
      enc = 1'b1;
      wr(`EWC_ADR_LIMIT, 32'h00000008);
      pkt(LEN, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_OK, 1'b0);
      pkt(LEN, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_OK, 1'b0);
      rd(`EWC_ADR_TOTAL, 32'h00000008);
      rd(`EWC_ADR_CTRL, 32'h00000002);
      pkt(LEN, RES, 8'h00, `EWC_TRAILER, 24'h0, `EWC_ST_PARAM, 1'b0);
      rd(`EWC_ADR_TOTAL, 32'h00000008);
      wr(`EWC_ADR_CTRL, 32'h00000004);
      rd(`EWC_ADR_TOTAL, 32'h00000000);
      rd(`EWC_ADR_CTRL, 32'h00000000);
      done("load");
      results();
   end
endmodule
